// File: nosi_pkg.sv
// Package with constants and types for the network option status indicators
package nosi_pkg;

    // Clock rate, flash half periods, start-up step and apply durations
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned HB_HALF_MS = 250;
    localparam int unsigned SLOW_HALF_MS = 750;
    localparam int unsigned STEP_MS = 250;
    localparam int unsigned APPLY_MS = 10;
    localparam int unsigned HB_HALF_CYC = CLK_HZ / 1000 * HB_HALF_MS;
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
    localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    localparam int unsigned APPLY_CYC = CLK_HZ / 1000 * APPLY_MS;

    // Mirror field positions: link, line-rate, fault, processor
    localparam int unsigned MIR_LINK_BIT = 3;
    localparam int unsigned MIR_RATE_BIT = 2;
    localparam int unsigned MIR_FAULT_BIT = 1;
    localparam int unsigned MIR_CPU_BIT = 0;
    localparam logic [3:0] MIR_RESET = 4'h0;

    typedef enum logic [2:0] {
        SEQ_MOD_GRN = 3'b000,
        SEQ_NET_RED = 3'b001,
        SEQ_MOD_RED = 3'b010,
        SEQ_NET_GRN = 3'b011,
        SEQ_NET_OFF = 3'b100,
        SEQ_DONE = 3'b101
    } nosi_seq_e;

    // Status conditions from the stack and the drive interface
    typedef struct packed {
        logic rate_100;
        logic link_ok;
        logic cpu_ok;
        logic ip_invalid;
        logic comm_lost;
        logic ip_dup;
        logic tcp_reg;
        logic class1_up;
        logic class1_lost;
        logic board_ok;
    } nosi_status_s;

    // Bicolour indicator drive
    typedef struct packed {
        logic green;
        logic red;
    } nosi_bicolor_s;

endpackage

// File: nosi_flash_div.sv
// Free running divider that toggles a flash phase every half period
`timescale 1ns/1ns
module nosi_flash_div #(
    parameter int unsigned HALF_CYC = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sync_clr_i,
    output logic phase_o
);
    localparam int unsigned CW = $clog2(HALF_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            phase_o <= 1'b0;
        end else if (sync_clr_i) begin
            cnt_reg <= '0;
            phase_o <= 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
            phase_o <= ~phase_o;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end
endmodule

// File: nosi_indicators.sv
// Status indicator controller for the Ethernet option module
`timescale 1ns/1ns

// Operation
// - Line-rate green on at 100, off 10
// - Link green on while link valid
// - Modbus: processor indicator flashes as heartbeat
// - Modbus: fault off without errors
// - Modbus: fault steady on for invalid IP
// - Modbus: fault flashes with processor on loss
// - Modbus: duplicate IP gives slower fault flash
// - EIP: network green steady with Class 1
// - EIP: network green off without TCP
// - EIP: network green flashes when registered
// - EIP: network red steady on duplicate IP
// - EIP: network red flashes on Class 1 loss
// - EIP: module green steady while board healthy
// - EIP: module red steady for invalid IP
// - EIP: module red flashes on comm loss
// - EIP: indicator step sequence after each settings apply
// - Read-only mirror of four indicator states
// - Apply restarts comms, parameter self-clears
module nosi_indicators
    import nosi_pkg::*;
#(
    parameter int unsigned HB_HALF = HB_HALF_CYC,
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned STEP = STEP_CYC,
    parameter int unsigned APPLY = APPLY_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic proto_eip_i,
    input wire nosi_status_s status_i,
    input wire logic apply_wr_i,
    output logic settings_apply_param_o,
    output logic comm_restart_o,
    output logic rate_led_o,
    output logic link_led_o,
    output logic cpu_led_o,
    output logic fault_led_o,
    output nosi_bicolor_s network_status_indicator_o,
    output nosi_bicolor_s module_status_indicator_o,
    output logic [3:0] indicator_state_mirror_o,
    output logic proto_eip_o
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int unsigned SYNC_W = $bits(nosi_status_s) + 1;

    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] filt_reg;
    nosi_status_s st;
    logic proto_live;

    // Stack conditions come from another domain; accept a change only when
    // two settled stages agree, so a single-cycle glitch is never shown.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= {proto_eip_i, status_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            filt_reg <= '0;
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    filt_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    assign st = nosi_status_s'(filt_reg[SYNC_W-2:0]);
    assign proto_live = filt_reg[SYNC_W-1];

    // ==========================================================
    // Settings apply parameter
    // ==========================================================
    localparam int unsigned AW = $clog2(APPLY + 1);
    localparam logic [AW-1:0] APPLY_LAST = AW'(APPLY - 1);

    logic [AW-1:0] apply_cnt_reg;
    logic apply_reg;
    logic restart_pulse;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            apply_reg <= 1'b0;
            apply_cnt_reg <= '0;
        end else if (!apply_reg) begin
            apply_cnt_reg <= '0;
            if (apply_wr_i) begin
                apply_reg <= 1'b1;
            end
        end else if (apply_cnt_reg == APPLY_LAST) begin
            apply_reg <= 1'b0;
            apply_cnt_reg <= '0;
        end else begin
            apply_cnt_reg <= apply_cnt_reg + AW'(1);
        end
    end

    assign restart_pulse = apply_reg && (apply_cnt_reg == APPLY_LAST);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settings_apply_param_o <= 1'b0;
            comm_restart_o <= 1'b0;
        end else begin
            settings_apply_param_o <= apply_reg;
            comm_restart_o <= restart_pulse;
        end
    end

    // ==========================================================
    // Protocol latch
    // ==========================================================
    logic proto_reg;
    logic boot_reg;

    // The switch is honoured only on a restart (start-up latches the filter while still at its zero reset, so Modbus); moving it
    // while running must not change the protocol.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            proto_reg <= 1'b0;
            boot_reg <= 1'b1;
        end else if (boot_reg || restart_pulse) begin
            proto_reg <= proto_live;
            boot_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Flash timing
    // ==========================================================
    logic hb_phase;
    logic slow_phase;

    nosi_flash_div #(
        .HALF_CYC(HB_HALF)
    ) u_hb_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .sync_clr_i(restart_pulse),
        .phase_o(hb_phase)
    );

    nosi_flash_div #(
        .HALF_CYC(SLOW_HALF)
    ) u_slow_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .sync_clr_i(restart_pulse),
        .phase_o(slow_phase)
    );

    // ==========================================================
    // Start-up sequence
    // ==========================================================
    localparam int unsigned SW = $clog2(STEP + 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP - 1);

    nosi_seq_e seq_reg;
    logic [SW-1:0] step_cnt_reg;
    logic seq_start_reg;

    // Sequence restarts after every settings apply as well as after reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_start_reg <= 1'b1;
        end else begin
            seq_start_reg <= restart_pulse;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_reg <= SEQ_MOD_GRN;
            step_cnt_reg <= '0;
        end else if (seq_start_reg) begin
            seq_reg <= SEQ_MOD_GRN;
            step_cnt_reg <= '0;
        end else if (seq_reg != SEQ_DONE) begin
            if (step_cnt_reg == STEP_LAST) begin
                step_cnt_reg <= '0;
                case (seq_reg)
                    SEQ_MOD_GRN: seq_reg <= SEQ_NET_RED;
                    SEQ_NET_RED: seq_reg <= SEQ_MOD_RED;
                    SEQ_MOD_RED: seq_reg <= SEQ_NET_GRN;
                    SEQ_NET_GRN: seq_reg <= SEQ_NET_OFF;
                    SEQ_NET_OFF: seq_reg <= SEQ_DONE;
                    default: seq_reg <= SEQ_DONE;
                endcase
            end else begin
                step_cnt_reg <= step_cnt_reg + SW'(1);
            end
        end
    end

    // ==========================================================
    // Indicator decode
    // ==========================================================
    function automatic nosi_bicolor_s seq_pattern(input nosi_seq_e s, input logic is_net);
        nosi_bicolor_s r;
        r = '0;
        case (s)
            SEQ_MOD_GRN: r.green = !is_net;
            SEQ_NET_RED: r.red = is_net;
            SEQ_MOD_RED: r.red = !is_net;
            SEQ_NET_GRN: r.green = is_net;
            default: r = '0;
        endcase
        return r;
    endfunction

    logic cpu_next;
    logic fault_next;
    nosi_bicolor_s net_next;
    nosi_bicolor_s mod_next;

    always_comb begin
        cpu_next = st.cpu_ok & hb_phase;
        if (st.ip_invalid) begin
            fault_next = 1'b1;
        end else if (st.comm_lost) begin
            fault_next = hb_phase;
        end else if (st.ip_dup) begin
            fault_next = slow_phase;
        end else begin
            fault_next = 1'b0;
        end
    end

    always_comb begin
        net_next = '0;
        mod_next = '0;
        if (st.ip_dup) begin
            net_next.red = 1'b1;
        end else if (st.class1_lost) begin
            net_next.red = slow_phase;
        end else if (st.class1_up) begin
            net_next.green = 1'b1;
        end else if (st.tcp_reg) begin
            net_next.green = hb_phase;
        end
        // no TCP green off happens by default above
        if (st.ip_invalid) begin
            mod_next.red = 1'b1;
        end else if (st.comm_lost) begin
            mod_next.red = hb_phase;
        end else if (st.board_ok) begin
            mod_next.green = 1'b1;
        end
        if (seq_reg != SEQ_DONE) begin
            net_next = seq_pattern(seq_reg, 1'b1);
            mod_next = seq_pattern(seq_reg, 1'b0);
        end
    end

    // ==========================================================
    // Output registers
    // ==========================================================
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rate_led_o <= 1'b0;
            link_led_o <= 1'b0;
            proto_eip_o <= 1'b0;
        end else begin
            rate_led_o <= st.rate_100;
            link_led_o <= st.link_ok;
            proto_eip_o <= proto_reg;
        end
    end

    // Only the indicator set of the latched protocol is lit; the other
    // stays dark so a board fitted with both sets never shows both.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_led_o <= 1'b0;
            fault_led_o <= 1'b0;
            network_status_indicator_o <= '0;
            module_status_indicator_o <= '0;
        end else begin
            cpu_led_o <= !proto_reg & cpu_next;
            fault_led_o <= !proto_reg & fault_next;
            network_status_indicator_o <= proto_reg ? net_next : '0;
            module_status_indicator_o <= proto_reg ? mod_next : '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            indicator_state_mirror_o <= MIR_RESET;
        end else begin
            indicator_state_mirror_o[MIR_LINK_BIT] <= st.link_ok;
            indicator_state_mirror_o[MIR_RATE_BIT] <= st.rate_100;
            indicator_state_mirror_o[MIR_FAULT_BIT] <= !proto_reg & fault_next;
            indicator_state_mirror_o[MIR_CPU_BIT] <= !proto_reg & cpu_next;
        end
    end
endmodule

// File: nosi_status_model.sv
// Behavioural model of the network client and drive interface
`timescale 1ns/1ns
module nosi_status_model
    import nosi_pkg::*;
(
    input wire logic core_clk_i,
    input wire nosi_status_s want_i,
    output nosi_status_s status_o,
    output logic apply_ok_o
);
    nosi_status_s next_st;
    // ==========
    // Conditions move on the falling edge, clear of the sampling edge
    always @(negedge core_clk_i) begin
        next_st = want_i;
        // A cyclic connection cannot exist without a registered client
        next_st.class1_up = want_i.class1_up & want_i.tcp_reg;
        status_o <= next_st;
    end
    assign apply_ok_o = !status_o.class1_up;
endmodule

// File: nosi_indicators_checker.sv
// Assertions for the status indicator controller
`timescale 1ns/1ns
module nosi_indicators_checker
    import nosi_pkg::*;
#(
    parameter int unsigned HB_HALF = 4,
    parameter int unsigned SLOW_HALF = 12,
    parameter int unsigned STEP = 8,
    parameter int unsigned APPLY = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic proto_eip_i,
    input wire nosi_status_s status_i,
    input wire logic apply_wr_i,
    input wire logic settings_apply_param_o,
    input wire logic comm_restart_o,
    input wire logic rate_led_o,
    input wire logic link_led_o,
    input wire logic cpu_led_o,
    input wire logic fault_led_o,
    input wire nosi_bicolor_s network_status_indicator_o,
    input wire nosi_bicolor_s module_status_indicator_o,
    input wire logic [3:0] indicator_state_mirror_o,
    input wire logic proto_eip_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Start-up steps occupy five steps; decode checks wait them out
    localparam int unsigned SETTLE = 5 * STEP + 8;
    int unsigned since_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_q <= 0;
        end else if (comm_restart_o) begin
            since_q <= 0;
        end else if (since_q < SETTLE) begin
            since_q <= since_q + 1;
        end
    end
    // An apply in progress re-times the flashers, so decode checks pause
    wire logic settled = (since_q >= SETTLE) && !settings_apply_param_o;
    sequence s_steps;
        module_status_indicator_o == 2'h2 ##8 network_status_indicator_o == 2'h1 ##8
        module_status_indicator_o == 2'h1 ##8 network_status_indicator_o == 2'h2 ##8
        network_status_indicator_o == 2'h0 && module_status_indicator_o == 2'h0;
    endsequence
    sequence s_busy;
        settings_apply_param_o[*3] ##1 !settings_apply_param_o;
    endsequence
    rate_follow_a: assert property (
        ($stable(status_i.rate_100))[*6] |-> rate_led_o == status_i.rate_100) else $error("rate lamp wrong");
    link_follow_a: assert property (
        ($stable(status_i.link_ok))[*6] |-> link_led_o == status_i.link_ok) else $error("link lamp wrong");
    mirror_match_a: assert property (
        ($stable({status_i.link_ok, status_i.rate_100}))[*6]
        |-> indicator_state_mirror_o == {status_i.link_ok, status_i.rate_100, fault_led_o, cpu_led_o})
        else $error("mirror wrong");
    eip_gate_a: assert property (
        (proto_eip_o)[*3] |-> !cpu_led_o && !fault_led_o) else $error("modbus lamps lit in eip");
    apply_busy_a: assert property (
        apply_wr_i && !settings_apply_param_o && !$past(apply_wr_i) |=> ##1 s_busy)
        else $error("apply busy span wrong");
    fault_steady_a: assert property (
        (!proto_eip_o && status_i.ip_invalid)[*6] |-> fault_led_o) else $error("fault not steady");
    sync_flash_a: assert property (
        (!proto_eip_o && status_i.comm_lost && status_i.cpu_ok && !status_i.ip_invalid)[*6]
        |-> fault_led_o == cpu_led_o) else $error("fault not with cpu");
    hb_period_a: assert property (
        disable iff (!rst_n_i || settings_apply_param_o)
        !proto_eip_o && settled && status_i.cpu_ok && $changed(cpu_led_o)
        |=> ($stable(cpu_led_o))[*3] ##1 $changed(cpu_led_o)) else $error("heartbeat period wrong");
    net_dup_red_a: assert property (
        (proto_eip_o && settled && status_i.ip_dup)[*6] |-> network_status_indicator_o == 2'h1)
        else $error("network red missing");
    mod_invalid_a: assert property (
        (proto_eip_o && settled && status_i.ip_invalid)[*6] |-> module_status_indicator_o == 2'h1)
        else $error("module red missing");
    startup_order_a: assert property (
        proto_eip_o && since_q == 4 |-> s_steps) else $error("start-up order wrong");
endmodule

bind nosi_indicators nosi_indicators_checker #(.HB_HALF(HB_HALF), .SLOW_HALF(SLOW_HALF), .STEP(STEP), .APPLY(APPLY))
    i_nosi_indicators_checker (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .proto_eip_i(proto_eip_i),
    .status_i(status_i), .apply_wr_i(apply_wr_i), .settings_apply_param_o(settings_apply_param_o),
    .comm_restart_o(comm_restart_o), .rate_led_o(rate_led_o), .link_led_o(link_led_o), .cpu_led_o(cpu_led_o),
    .fault_led_o(fault_led_o), .network_status_indicator_o(network_status_indicator_o),
    .module_status_indicator_o(module_status_indicator_o),
    .indicator_state_mirror_o(indicator_state_mirror_o), .proto_eip_o(proto_eip_o));

// File: nosi_indicators_test.sv
// Self-checking testbench for the status indicator controller
`timescale 1ns/1ns
module nosi_indicators_test;
    import nosi_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic proto_eip_i = 1'b0;
    logic apply_wr_i = 1'b0;
    nosi_status_s want = nosi_status_s'(10'h381);
    nosi_status_s status;
    logic apply_ok, param, restart, rate_led, link_led, cpu_led, fault_led, proto;
    nosi_bicolor_s net_ind, mod_ind;
    logic [3:0] mirror;
    wire logic [5:0] lamps = {net_ind, mod_ind, fault_led, cpu_led};
    int fail_count = 0;
    int samples_checked = 0;

    always #25 core_clk_i = ~core_clk_i;

    nosi_status_model i_nosi_status_model (.core_clk_i(core_clk_i), .want_i(want), .status_o(status),
        .apply_ok_o(apply_ok));
    nosi_indicators #(.HB_HALF(4), .SLOW_HALF(12), .STEP(8), .APPLY(3)) i_nosi_indicators (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .proto_eip_i(proto_eip_i), .status_i(status),
        .apply_wr_i(apply_wr_i), .settings_apply_param_o(param), .comm_restart_o(restart),
        .rate_led_o(rate_led), .link_led_o(link_led), .cpu_led_o(cpu_led), .fault_led_o(fault_led),
        .network_status_indicator_o(net_ind), .module_status_indicator_o(mod_ind),
        .indicator_state_mirror_o(mirror), .proto_eip_o(proto));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    // Lamp code per lamp: 0 off, 1 slow flash, 3 fast flash, 2 steady
    task automatic run_row(input string name, input logic [9:0] cond, input logic [11:0] exp);
        int on [6] = '{default: 0};
        int tg [6] = '{default: 0};
        logic [5:0] prev;
        logic [11:0] code;
        want <= nosi_status_s'(cond);
        cyc(8);
        prev = lamps;
        repeat (26) begin
            @(negedge core_clk_i);
            for (int i = 0; i < 6; i++) begin
                on[i] += int'(lamps[i] === 1'b1);
                tg[i] += int'(lamps[i] !== prev[i]);
            end
            prev = lamps;
        end
        for (int i = 0; i < 6; i++) begin
            code[2*i +: 2] = (on[i] == 0) ? 2'h0 : (on[i] == 26) ? 2'h2 : (tg[i] > 3) ? 2'h3 : 2'h1;
        end
        check(name, code, exp);
    endtask

    task automatic t_line;
        for (int i = 0; i < 4; i++) begin
            want.rate_100 <= i[0];
            want.link_ok <= i[1];
            cyc(9);
            check("rate", {11'h0, rate_led}, {11'h0, i[0]});
            check("link", {11'h0, link_led}, {11'h0, i[1]});
            check("mirror", {10'h0, mirror[3:2]}, {10'h0, i[1:0]});
        end
    endtask

    task automatic t_modbus;
        run_row("mb idle", 10'h380, 12'h003);
        run_row("mb bad ip", 10'h3c0, 12'h00b);
        run_row("mb lost", 10'h3a0, 12'h00f);
        run_row("mb dup", 10'h390, 12'h007);
        run_row("mb both", 10'h3e0, 12'h00b);
    endtask

    task automatic t_apply;
        int hi = 0;
        int pulses = 0;
        want <= nosi_status_s'(10'h380);
        proto_eip_i <= 1'b1;
        cyc(8);
        check("apply allowed", {11'h0, apply_ok}, 12'h001);
        apply_wr_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(negedge core_clk_i);
            if (i == 1) begin
                apply_wr_i <= 1'b0;
            end
            hi += int'(param === 1'b1);
            pulses += int'(restart === 1'b1);
        end
        check("apply busy", 12'(hi), 12'h003);
        check("restart pulses", 12'(pulses), 12'h001);
        check("protocol", {11'h0, proto}, 12'h001);
        cyc(48);
    endtask

    task automatic t_eip;
        run_row("eip idle", 10'h381, 12'h080);
        run_row("eip tcp", 10'h389, 12'hc80);
        run_row("eip class1", 10'h38d, 12'h880);
        run_row("eip dup", 10'h399, 12'h280);
        run_row("eip c1 lost", 10'h38b, 12'h180);
        run_row("eip board bad", 10'h380, 12'h000);
        run_row("eip bad ip", 10'h3c1, 12'h020);
        run_row("eip lost", 10'h3a1, 12'h030);
    endtask

    initial begin
        #150000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        cyc(6);
        rst_n_i <= 1'b1;
        cyc(2);
        t_line();
        t_modbus();
        t_apply();
        t_eip();
        report_and_stop();
    end
endmodule
